// *** common/uir_pkg.sv ***
package uir_pkg;
  localparam int unsigned N_EP = 6;

  // Register byte addresses
  localparam logic [7:0] OFS_ENABLE  = 8'h10;
  localparam logic [7:0] OFS_DISABLE = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_CLEAR   = 8'h20;
  localparam logic [7:0] OFS_BUSCTL  = 8'h24;

  // Field positions
  localparam int unsigned BIT_SUSPEND = 8;
  localparam int unsigned BIT_RESUME  = 9;
  localparam int unsigned BIT_SOF     = 11;
  localparam int unsigned BIT_BUSRST  = 12;
  localparam int unsigned BIT_WAKEUP  = 13;

  // Bits that the enable registers may touch: endpoints, 8, 9, 11, 13
  localparam logic [31:0] ENABLE_BITS = 32'h0000_2b3f;
  // Bits that the clear register may touch: 8, 9, 11, 12, 13
  localparam logic [31:0] CLEAR_BITS  = 32'h0000_3b00;
  // Resume enabled from reset
  localparam logic [31:0] ENABLE_RST  = 32'h0000_0200;
  localparam logic [31:0] UNMASKABLE  = 32'h0000_1000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // Suspend detection: 3 ms idle
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned IDLE_SUSPEND_US = 3000;
  localparam int unsigned IDLE_CYCLES    = IDLE_SUSPEND_US * CLK_MHZ;

  // Per-endpoint transaction flags
  typedef struct packed {
    logic setup_received;
    logic rx_bank0_full;
    logic rx_bank1_full;
    logic tx_complete;
    logic stall_acknowledged;
  } uir_ep_flags_type;

  // Bus events from the USB engine: activity is a level, the others last one cycle
  typedef struct packed {
    logic activity;
    logic resume_seen;
    logic sof_token;
    logic bus_reset_end;
    logic bus_reset_seen;
  } uir_bus_events_type;
endpackage

// *** src/uir_regs.sv ***
`timescale 1ns/1ps
// How it works
// - Disable write with bit 0..5 set clears that endpoint enable; zeros ignored.
// - Disable write bits 8, 9, 11, 13 clear the matching bus-event enable.
// - Mask register reads 1 for each enabled interrupt, 0 for disabled.
// - Mask bit 12 (bus reset done) always reads 1.
// - Resume enable is set after reset.
// - Endpoint status is high while any of its five flags is set.
// - Endpoint status clears only via its control/status flags, not the clear register.
// - 3 ms without bus activity sets suspend status and enters suspend.
// - Detected resume signalling sets resume status.
// - Resume or reset from host sets wakeup status until cleared.
// - Each SOF token sets start-of-frame status.
// - End of bus reset sets bus-reset-done status.
// - Clear write with ones clears bus-event status bits; zeros ignored.
// - Enable write with ones sets the matching enables; zeros ignored.
module uir_regs
  import uir_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_CYCLES
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [7:0]                   i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  input  wire uir_pkg::uir_ep_flags_type [5:0] i_ep_flags,
  input  wire uir_pkg::uir_bus_events_type  i_bus_events,
  output logic                              o_suspended,
  output logic                              o_irq
);
  import uir_pkg::*;

  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_IDLE    = 2'b01,
    ST_SUSPEND = 2'b11
  } uir_state_type;

  // Bus decode
  logic            wr_access;
  logic            rd_setup;
  logic            any_access;
  logic            addr_ok;
  logic            enable_wr;
  logic            disable_wr;
  logic            clear_wr;
  logic [31:0]     en_set;
  logic [31:0]     en_clr;
  logic [31:0]     st_clr;

  // Enables
  logic [N_EP-1:0] ep_enable;
  logic            suspend_enable;
  logic            resume_enable;
  logic            frame_start_enable;
  logic            wakeup_enable;

  // Status
  logic [N_EP-1:0] ep_pending;
  logic            suspend_irq;
  logic            resume_irq;
  logic            frame_start_irq;
  logic            bus_reset_done_irq;
  logic            wakeup_irq;
  logic [31:0]     status;
  logic [31:0]     mask;
  logic [31:0]     ctl_word;
  logic [31:0]     next_prdata;

  // Suspend detection
  logic [31:0]     idle_count;
  logic [31:0]     next_idle_count;
  logic            idle_done;
  uir_state_type   state;
  uir_state_type   next_state;

  function automatic logic reg_hit(input logic access, input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = access && (addr == ofs);
  endfunction

  function automatic logic known_addr(input logic [7:0] addr);
    known_addr = (addr == OFS_ENABLE) ||
                 (addr == OFS_DISABLE) ||
                 (addr == OFS_MASK) ||
                 (addr == OFS_STATUS) ||
                 (addr == OFS_CLEAR) ||
                 (addr == OFS_BUSCTL);
  endfunction

  // Set wins, so an event landing on its clear cycle is not lost; for enables
  // set and clear sit at different addresses and never meet
  function automatic logic set_clr_next(input logic held, input logic set_now,
                                        input logic clr_now);
    set_clr_next = set_now || (held && !clr_now);
  endfunction

  function automatic logic any_flag(input uir_ep_flags_type flags);
    any_flag = flags.setup_received ||
               flags.rx_bank0_full ||
               flags.rx_bank1_full ||
               flags.tx_complete ||
               flags.stall_acknowledged;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0]  addr,
                                            input logic [31:0] mask_word,
                                            input logic [31:0] status_word,
                                            input logic [31:0] ctl);
    case (addr)
      OFS_MASK: begin
        read_word = mask_word;
      end
      OFS_STATUS: begin
        read_word = status_word;
      end
      OFS_BUSCTL: begin
        read_word = ctl;
      end
      default: begin
        // Write-only and unmapped addresses read zero
        read_word = ZERO_WORD;
      end
    endcase
  endfunction

  assign any_access = i_psel && i_penable;
  assign wr_access  = any_access && i_pwrite;
  assign rd_setup   = i_psel && !i_penable && !i_pwrite;
  assign addr_ok    = known_addr(i_paddr);
  assign enable_wr  = reg_hit(wr_access, i_paddr, OFS_ENABLE);
  assign disable_wr = reg_hit(wr_access, i_paddr, OFS_DISABLE);
  assign clear_wr   = reg_hit(wr_access, i_paddr, OFS_CLEAR);

  // Zero wait states: every access phase completes at its first edge
  assign o_pready  = 1'b1;
  assign o_pslverr = any_access && !addr_ok;

  // Bits outside the writable sets never reach a flop
  assign en_set = enable_wr ? (i_pwdata & ENABLE_BITS) : ZERO_WORD;
  assign en_clr = disable_wr ? (i_pwdata & ENABLE_BITS) : ZERO_WORD;
  assign st_clr = clear_wr ? (i_pwdata & CLEAR_BITS) : ZERO_WORD;

  // Endpoint enables
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ep_enable <= ENABLE_RST[N_EP-1:0];
    end else begin
      for (int i = 0; i < N_EP; i++) begin
        ep_enable[i] <= set_clr_next(ep_enable[i], en_set[i], en_clr[i]);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      suspend_enable <= ENABLE_RST[BIT_SUSPEND];
    end else begin
      suspend_enable <= set_clr_next(suspend_enable, en_set[BIT_SUSPEND],
                                     en_clr[BIT_SUSPEND]);
    end
  end

  // Resume starts enabled so a host resume is seen even after power-down
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resume_enable <= ENABLE_RST[BIT_RESUME];
    end else begin
      resume_enable <= set_clr_next(resume_enable, en_set[BIT_RESUME],
                                    en_clr[BIT_RESUME]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_start_enable <= ENABLE_RST[BIT_SOF];
    end else begin
      frame_start_enable <= set_clr_next(frame_start_enable, en_set[BIT_SOF],
                                         en_clr[BIT_SOF]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wakeup_enable <= ENABLE_RST[BIT_WAKEUP];
    end else begin
      wakeup_enable <= set_clr_next(wakeup_enable, en_set[BIT_WAKEUP],
                                    en_clr[BIT_WAKEUP]);
    end
  end

  // Endpoint status follows the flags, so only clearing the flags drops it
  always_comb begin
    for (int i = 0; i < N_EP; i++) begin
      ep_pending[i] = any_flag(i_ep_flags[i]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      suspend_irq <= ZERO_WORD[BIT_SUSPEND];
    end else begin
      suspend_irq <= set_clr_next(suspend_irq, idle_done,
                                  st_clr[BIT_SUSPEND]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resume_irq <= ZERO_WORD[BIT_RESUME];
    end else begin
      resume_irq <= set_clr_next(resume_irq, i_bus_events.resume_seen,
                                 st_clr[BIT_RESUME]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_start_irq <= ZERO_WORD[BIT_SOF];
    end else begin
      frame_start_irq <= set_clr_next(frame_start_irq, i_bus_events.sof_token,
                                      st_clr[BIT_SOF]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_reset_done_irq <= ZERO_WORD[BIT_BUSRST];
    end else begin
      bus_reset_done_irq <= set_clr_next(bus_reset_done_irq, i_bus_events.bus_reset_end,
                                         st_clr[BIT_BUSRST]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wakeup_irq <= ZERO_WORD[BIT_WAKEUP];
    end else begin
      wakeup_irq <= set_clr_next(wakeup_irq,
                                 i_bus_events.resume_seen || i_bus_events.bus_reset_seen,
                                 st_clr[BIT_WAKEUP]);
    end
  end

  always_comb begin
    status = ZERO_WORD;
    status[N_EP-1:0] = ep_pending;
    status[BIT_SUSPEND] = suspend_irq;
    status[BIT_RESUME] = resume_irq;
    status[BIT_SOF] = frame_start_irq;
    status[BIT_BUSRST] = bus_reset_done_irq;
    status[BIT_WAKEUP] = wakeup_irq;
  end

  always_comb begin
    mask = UNMASKABLE;
    mask[N_EP-1:0] = ep_enable;
    mask[BIT_SUSPEND] = suspend_enable;
    mask[BIT_RESUME] = resume_enable;
    mask[BIT_SOF] = frame_start_enable;
    mask[BIT_WAKEUP] = wakeup_enable;
  end

  assign o_irq = |(status & mask);

  // Activity in the very last idle cycle still cancels the suspend
  assign idle_done = (state == ST_IDLE) && !i_bus_events.activity &&
                     (idle_count == IDLE_LIMIT - 1);

  always_comb begin
    if (i_bus_events.activity || (state != ST_IDLE)) begin
      next_idle_count = ZERO_WORD;
    end else begin
      next_idle_count = idle_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_count <= ZERO_WORD;
    end else begin
      idle_count <= next_idle_count;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (!i_bus_events.activity) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (i_bus_events.activity) begin
          next_state = ST_ACTIVE;
        end else if (idle_done) begin
          next_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (i_bus_events.activity) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  assign o_suspended = (state == ST_SUSPEND);

  assign ctl_word = {30'h0, o_suspended, o_irq};

  always_comb begin
    next_prdata = read_word(i_paddr, mask, status, ctl_word);
  end

  // Loaded in the setup cycle so the word stands through the whole access phase
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= ZERO_WORD;
    end else if (rd_setup) begin
      o_prdata <= next_prdata;
    end
  end
endmodule

// *** verification/uir_host_model.sv ***
`timescale 1ns/1ps
module uir_host_model
  import uir_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_idle,
  input  wire logic [3:0]            i_req,
  output uir_pkg::uir_bus_events_type o_ev
);
  logic [3:0] pulse = 4'h0;
  // Line events last one clock, as the engine reports them
  always @(posedge i_mclk) pulse <= i_req;
  // A quiet bus carries no activity at all, so the idle timer may run
  assign o_ev = {!i_idle, pulse};
endmodule

// *** verification/uir_regs_monitor.sv ***
`timescale 1ns/1ps
module uir_regs_monitor
  import uir_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_CYCLES
) (
  input wire logic                      i_mclk,
  input wire logic                      i_rst_n,
  input wire logic                      i_psel,
  input wire logic                      i_penable,
  input wire logic                      i_pwrite,
  input wire logic [7:0]                i_paddr,
  input wire logic [31:0]               i_pwdata,
  input wire logic [31:0]               o_prdata,
  input wire logic                      o_pready,
  input wire uir_pkg::uir_ep_flags_type [5:0] i_ep_flags,
  input wire uir_pkg::uir_bus_events_type i_bus_events,
  input wire logic                      o_suspended,
  input wire logic                      o_irq
);
  logic [31:0] en;
  logic [5:0]  epo;
  int unsigned idle;
  wire acc = i_psel && i_penable;
  always_comb for (int k = 0; k < 6; k++) epo[k] = |i_ep_flags[k];
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) en <= ENABLE_RST;
    else if (acc && i_pwrite && i_paddr == OFS_ENABLE) en <= en | (i_pwdata & ENABLE_BITS);
    else if (acc && i_pwrite && i_paddr == OFS_DISABLE) en <= en & ~(i_pwdata & ENABLE_BITS);
  end
  // Saturates so a long quiet bus cannot wrap the count
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) idle <= 0;
    else if (i_bus_events.activity) idle <= 0;
    else if (idle < 1000) idle <= idle + 1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  ep_irq_a: assert property (|(epo & en[5:0]) |-> o_irq) else $error("ep irq");
  mask_read_a: assert property (acc && !i_pwrite && i_paddr == OFS_MASK
    |-> o_prdata == (en | UNMASKABLE)) else $error("mask");
  ep_status_a: assert property (acc && !i_pwrite && i_paddr == OFS_STATUS
    |-> o_prdata[5:0] == $past(epo)) else $error("ep status");
  sof_irq_a: assert property (i_bus_events.sof_token && en[BIT_SOF] |=> o_irq) else $error("sof");
  resume_irq_a: assert property (i_bus_events.resume_seen && en[BIT_RESUME] |=> o_irq)
    else $error("resume");
  wake_irq_a: assert property (i_bus_events.bus_reset_seen && en[BIT_WAKEUP] |=> o_irq)
    else $error("wakeup");
  busrst_irq_a: assert property (i_bus_events.bus_reset_end |=> o_irq [*2]) else $error("rst");
  susp_set_a: assert property (idle == IDLE_LIMIT + 1 |-> o_suspended) else $error("susp");
  susp_early_a: assert property (idle > 1 && idle <= IDLE_LIMIT |-> !o_suspended)
    else $error("early susp");
  cover property (o_suspended);
  cover property (acc && i_paddr == OFS_STATUS);
  cover property (i_bus_events.sof_token);
endmodule
bind uir_regs uir_regs_monitor #(.IDLE_LIMIT(IDLE_LIMIT)) uir_regs_monitor_inst (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .i_ep_flags(i_ep_flags), .i_bus_events(i_bus_events),
  .o_suspended(o_suspended), .o_irq(o_irq));

// *** verification/uir_regs_tb.sv ***
`timescale 1ns/1ps
module uir_regs_tb;
  import uir_pkg::*;
  logic                   clk, rst_n, psel, pen, pwr, slv, rdy, susp, irq, idle, sp, perr;
  logic [7:0]             addr;
  logic [31:0]            wd, rdat, got, en, st;
  logic [3:0]             req;
  logic [31:0]            evb [4] = '{32'h2000, 32'h1000, 32'h0800, 32'h2200};
  uir_ep_flags_type [5:0] ep;
  uir_bus_events_type     ev;
  int                     num_errors, comparisons, seed, i;
  uir_regs #(.IDLE_LIMIT(20)) uir_regs_inst (.i_mclk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(rdat),
    .o_pready(rdy), .o_pslverr(slv), .i_ep_flags(ep), .i_bus_events(ev),
    .o_suspended(susp), .o_irq(irq));
  uir_host_model uir_host_model_inst (.i_mclk(clk), .i_idle(idle), .i_req(req), .o_ev(ev));
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    got = rdat;
    perr = slv;
    psel <= 1'b0;
    pen <= 1'b0;
    if (w && a == OFS_ENABLE) en |= d & ENABLE_BITS;
    if (w && a == OFS_DISABLE) en &= ~(d & ENABLE_BITS);
    if (w && a == OFS_CLEAR) st &= ~(d & CLEAR_BITS);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] s;
    xf(1'b0, a, 32'h0);
    s = st;
    for (int k = 0; k < 6; k++) s[k] = |ep[k];
    ck(32'(susp), 32'(sp));
    ck(32'(irq), 32'(|(s & (en | UNMASKABLE))));
    case (a)
      OFS_MASK:   ck(got, en | UNMASKABLE);
      OFS_STATUS: ck(got, s);
      OFS_BUSCTL: ck(got, {30'h0, sp, |(s & (en | UNMASKABLE))});
      default:    ck(32'(perr), 32'h1);
    endcase
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    {rst_n, psel, pen, pwr, idle, sp, addr, wd, req, ep} = '0;
    {seed, en, st} = {32'd49, ENABLE_RST, ZERO_WORD};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_MASK);
    xf(1'b1, OFS_CLEAR, CLEAR_BITS);
    rd(OFS_STATUS);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      xf(1'b1, OFS_ENABLE, $random(seed));
      ep <= 30'($random(seed));
      rd(OFS_MASK);
      xf(1'b1, (i[0] ? OFS_CLEAR : OFS_DISABLE), $random(seed));
      rd(OFS_MASK);
      rd(OFS_STATUS);
    end
    $display("mask test done");
    xf(1'b1, OFS_ENABLE, ENABLE_BITS);
    for (i = 0; i < 4; i++) begin
      req <= 4'h1 << i;
      @(posedge clk);
      req <= 4'h0;
      repeat (2) @(posedge clk);
      st |= evb[i];
      rd(OFS_STATUS);
      xf(1'b1, OFS_CLEAR, $random(seed));
      rd(OFS_STATUS);
    end
    $display("event test done");
    idle <= 1'b1;
    repeat (30) @(posedge clk);
    {sp, st} = {1'b1, st | 32'h0100};
    rd(OFS_BUSCTL);
    idle <= 1'b0;
    repeat (3) @(posedge clk);
    sp = 1'b0;
    rd(OFS_BUSCTL);
    rd(8'hfc);
    $display("suspend test done");
    give_verdict();
  end
endmodule
